// ==== logic/vop_pkg.sv ====
// Constants and carrier types for the video output processor
// What this block does
// - Store the burst loop error into an 8-bit readable register once per line.
// - Demodulator bypass bit routes component chroma around the demodulator.
// - Gaussian bypass bit routes chroma around the demodulation low pass filter.
// - Chroma coring zeroes chroma samples below a programmable threshold.
// - Line grab bit captures one line into the first linestore, forces simple comb.
// - Blank level select picks 240, 256, external video or low-passed luma on clamp.
// - Subtract blanking from luma; negatives take the sync path, positives pedestal.
// - Subtract 8-bit pedestal; super-black clipped unless the pass bit is high.
// - Clamp enable bit drives a 0.5 us negative clamp pulse on the aux pin.
// - Clamp pulse starts two clocks more than the programmed count after each hsync.
// - Adaptive notch threshold: 00 gives 16, 01 gives 12, 10 gives 8, 11 gives 4.
// - Coring output size picks 8 or 10 bits; filtered rounds, bypassed truncates.
// - Luma notch bit enables a fixed notch at one quarter of the sample rate.
// - U gain scales U to blue difference, range 0 to 2047/256.
// - V, Y and sync gains range 0 to 1023/256.
// - Sync gain during burst blanking, luma gain on active lines.
// - RGB green difference is -1043/2048 of red minus 398/2048 of blue.
// - Add 8-bit offset to all RGB outputs or to luma only for YCbCr.
// - Limiter codes clamp RGB or Y and chroma to the four tabled ranges.
// - RGB magnitude set only by luma, U and V gains, no per-channel gain.
`default_nettype none
package vop_pkg;
  localparam int DW = 10;
  // Register offsets on the microprocessor port
  localparam logic [7:0] REG_SB_CTRL = 8'h0A;
  localparam logic [7:0] REG_U_GAIN_LO = 8'h17;
  localparam logic [7:0] REG_U_GAIN_HI = 8'h18;
  localparam logic [7:0] REG_V_GAIN_LO = 8'h19;
  localparam logic [7:0] REG_V_GAIN_HI = 8'h1A;
  localparam logic [7:0] REG_Y_GAIN_LO = 8'h1B;
  localparam logic [7:0] REG_Y_GAIN_HI = 8'h1C;
  localparam logic [7:0] REG_S_GAIN_LO = 8'h1D;
  localparam logic [7:0] REG_S_GAIN_HI = 8'h1E;
  localparam logic [7:0] REG_CTRL_A = 8'h20;
  localparam logic [7:0] REG_CTRL_B = 8'h21;
  localparam logic [7:0] REG_CORE_THR = 8'h22;
  localparam logic [7:0] REG_PEDESTAL = 8'h23;
  localparam logic [7:0] REG_CLAMP_CTRL = 8'h24;
  localparam logic [7:0] REG_CLAMP_POS = 8'h25;
  localparam logic [7:0] REG_Y_OFFSET = 8'h26;
  localparam logic [7:0] REG_BURST_ERR = 8'h40;
  // Bit positions
  localparam int SB_PASS_BIT = 4;
  localparam int CLAMP_EN_BIT = 7;
  localparam int A_DEMOD_BY = 0;
  localparam int A_GAUSS_BY = 1;
  localparam int A_FILT2 = 2;
  localparam int A_CCORE_EN = 3;
  localparam int A_LINE_GRAB = 4;
  localparam int A_ANOTCH_EN = 5;
  localparam int A_LNOTCH = 6;
  localparam int A_CORING_OUTPUT_SIZE = 7;
  localparam int B_BLANK_LO = 0;
  localparam int B_THR_LO = 2;
  localparam int B_LMT_LO = 4;
  // Reset value of the gains: unity with 8 fraction bits (3.8 for U, 2.8 for the rest)
  localparam logic [10:0] GAIN_UNITY = 11'h100;
  // Blanking levels and notch thresholds
  localparam logic signed [12:0] BLANK_240 = 13'sh0F0;
  localparam logic signed [12:0] BLANK_256 = 13'sh100;
  localparam logic [11:0] THR_0 = 12'h010;
  localparam logic [11:0] THR_1 = 12'h00C;
  localparam logic [11:0] THR_2 = 12'h008;
  localparam logic [11:0] THR_3 = 12'h004;
  // Fixed green difference weights over 2048
  localparam logic signed [12:0] G_FROM_V = 13'sh413;
  localparam logic signed [12:0] G_FROM_U = 13'sh18E;
  // Limiter ranges
  localparam logic signed [13:0] LIM_FULL_HI = 14'sh03FF;
  localparam logic signed [13:0] LIM_STD_LO = 14'sh0040;
  localparam logic signed [13:0] LIM_STD_HI = 14'sh03AC;
  localparam logic signed [13:0] LIM_C_FULL = 14'sh01FF;
  localparam logic signed [13:0] LIM_C_STD = 14'sh01C0;
  // Clamp pulse timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLAMP_WIDTH_NS = 500;
  localparam logic [7:0] CLAMP_CYCLES = 8'((CLAMP_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum logic [2:0] {
    VOP_CLP_IDLE = 3'b001,
    VOP_CLP_WAIT = 3'b010,
    VOP_CLP_PULSE = 3'b100
  } vop_clamp_st_t;
  typedef struct packed {
    logic [DW-1:0] y;
    logic signed [DW-1:0] u;
    logic signed [DW-1:0] v;
  } vop_pix_t;
  typedef struct packed {
    logic [DW-1:0] g_y;
    logic [DW-1:0] b_u;
    logic [DW-1:0] r_v;
  } vop_out_t;
endpackage
`default_nettype wire

// ==== logic/vop_output_processor.sv ====
// Video output processor: chroma path, clamp, pedestal, notch, matrix, limiters, FIFO
`timescale 1ns/1ps
`default_nettype none

module vop_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;
  assign rd_data = mem[rp_r];
  // Storage has no reset; only pointers, count and flags carry state
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_r] <= wr_data;
    end
  end
  // Pointers and flags kept as flops so ready and valid are glitch free
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      wr_ready <= 1'b0;
      rd_valid <= 1'b0;
    end else begin
      if (push) begin
        wp_r <= AW'(wp_r + 1'b1);
      end
      if (pop) begin
        rp_r <= AW'(rp_r + 1'b1);
      end
      cnt_r <= (AW+1)'(cnt_r + push - pop);
      wr_ready <= (AW+1)'(cnt_r + push - pop) != (AW+1)'(DEPTH);
      rd_valid <= (AW+1)'(cnt_r + push - pop) != '0;
    end
  end
endmodule

module vop_output_processor #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] up_addr,
  input wire logic [7:0] up_wdata,
  input wire logic up_wr,
  input wire logic up_rd,
  output logic [7:0] up_rdata,
  input wire logic in_valid,
  output logic in_ready,
  input wire vop_pkg::vop_pix_t in_pix,
  input wire logic signed [vop_pkg::DW-1:0] comp_u,
  input wire logic signed [vop_pkg::DW-1:0] comp_v,
  input wire logic burst_blank,
  input wire logic hsync,
  input wire logic burst_gate,
  input wire logic [vop_pkg::DW-1:0] ext_video_input,
  input wire logic [7:0] burst_err,
  output logic out_valid,
  input wire logic out_ready,
  output vop_pkg::vop_out_t out_pix,
  output logic aux_video_out_pin,
  output logic first_linestore_we,
  output logic comb_force_simple
);
  localparam int DW = vop_pkg::DW;
  // Register file
  logic [7:0] sb_ctrl_r, ctrl_a_r, ctrl_b_r, core_thr_r, pedestal_r;
  logic [7:0] clamp_ctrl_r, clamp_pos_r, y_offset_r, burst_err_r;
  logic [10:0] u_gain_r;
  logic [9:0] v_gain_r, y_gain_r, s_gain_r;
  logic hsync_d_r, gate_d_r, hs_edge, gate_edge;
  logic adv;
  logic [4:0] vld_r;
  assign hs_edge = hsync && !hsync_d_r;
  assign gate_edge = burst_gate && !gate_d_r;
  // The whole pipeline advances only when the FIFO can take a word
  assign adv = in_ready;

  // Host writes; gains split over low and high byte registers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sb_ctrl_r <= 8'h00;
      ctrl_a_r <= 8'h00;
      ctrl_b_r <= 8'h00;
      core_thr_r <= 8'h00;
      pedestal_r <= 8'h00;
      clamp_ctrl_r <= 8'h00;
      clamp_pos_r <= 8'h00;
      y_offset_r <= 8'h00;
      u_gain_r <= vop_pkg::GAIN_UNITY;
      v_gain_r <= 10'(vop_pkg::GAIN_UNITY);
      y_gain_r <= 10'(vop_pkg::GAIN_UNITY);
      s_gain_r <= 10'(vop_pkg::GAIN_UNITY);
    end else if (up_wr) begin
      case (up_addr)
        vop_pkg::REG_SB_CTRL: sb_ctrl_r <= up_wdata;
        vop_pkg::REG_CTRL_A: ctrl_a_r <= up_wdata;
        vop_pkg::REG_CTRL_B: ctrl_b_r <= up_wdata;
        vop_pkg::REG_CORE_THR: core_thr_r <= up_wdata;
        vop_pkg::REG_PEDESTAL: pedestal_r <= up_wdata;
        vop_pkg::REG_CLAMP_CTRL: clamp_ctrl_r <= up_wdata;
        vop_pkg::REG_CLAMP_POS: clamp_pos_r <= up_wdata;
        vop_pkg::REG_Y_OFFSET: y_offset_r <= up_wdata;
        vop_pkg::REG_U_GAIN_LO: u_gain_r[7:0] <= up_wdata;
        vop_pkg::REG_U_GAIN_HI: u_gain_r[10:8] <= up_wdata[2:0];
        vop_pkg::REG_V_GAIN_LO: v_gain_r[7:0] <= up_wdata;
        vop_pkg::REG_V_GAIN_HI: v_gain_r[9:8] <= up_wdata[1:0];
        vop_pkg::REG_Y_GAIN_LO: y_gain_r[7:0] <= up_wdata;
        vop_pkg::REG_Y_GAIN_HI: y_gain_r[9:8] <= up_wdata[1:0];
        vop_pkg::REG_S_GAIN_LO: s_gain_r[7:0] <= up_wdata;
        vop_pkg::REG_S_GAIN_HI: s_gain_r[9:8] <= up_wdata[1:0];
        default: ;
      endcase
    end
  end

  // Host reads, one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      up_rdata <= 8'h00;
    end else if (up_rd) begin
      case (up_addr)
        vop_pkg::REG_SB_CTRL: up_rdata <= sb_ctrl_r;
        vop_pkg::REG_CTRL_A: up_rdata <= ctrl_a_r;
        vop_pkg::REG_CTRL_B: up_rdata <= ctrl_b_r;
        vop_pkg::REG_CORE_THR: up_rdata <= core_thr_r;
        vop_pkg::REG_PEDESTAL: up_rdata <= pedestal_r;
        vop_pkg::REG_CLAMP_CTRL: up_rdata <= clamp_ctrl_r;
        vop_pkg::REG_CLAMP_POS: up_rdata <= clamp_pos_r;
        vop_pkg::REG_Y_OFFSET: up_rdata <= y_offset_r;
        vop_pkg::REG_U_GAIN_LO: up_rdata <= u_gain_r[7:0];
        vop_pkg::REG_U_GAIN_HI: up_rdata <= {5'h00, u_gain_r[10:8]};
        vop_pkg::REG_V_GAIN_LO: up_rdata <= v_gain_r[7:0];
        vop_pkg::REG_V_GAIN_HI: up_rdata <= {6'h00, v_gain_r[9:8]};
        vop_pkg::REG_Y_GAIN_LO: up_rdata <= y_gain_r[7:0];
        vop_pkg::REG_Y_GAIN_HI: up_rdata <= {6'h00, y_gain_r[9:8]};
        vop_pkg::REG_S_GAIN_LO: up_rdata <= s_gain_r[7:0];
        vop_pkg::REG_S_GAIN_HI: up_rdata <= {6'h00, s_gain_r[9:8]};
        vop_pkg::REG_BURST_ERR: up_rdata <= burst_err_r;
        default: up_rdata <= 8'h00;
      endcase
    end
  end

  // Edge detectors and the once-per-line loop error snapshot
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hsync_d_r <= 1'b0;
      gate_d_r <= 1'b0;
      burst_err_r <= 8'h00;
    end else begin
      hsync_d_r <= hsync;
      gate_d_r <= burst_gate;
      if (hs_edge) begin
        burst_err_r <= burst_err;
      end
    end
  end

  // Line grab: armed by the control bit, writes exactly the next whole line
  logic grab_done_r;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      first_linestore_we <= 1'b0;
      grab_done_r <= 1'b0;
      comb_force_simple <= 1'b0;
    end else begin
      comb_force_simple <= ctrl_a_r[vop_pkg::A_LINE_GRAB];
      if (!ctrl_a_r[vop_pkg::A_LINE_GRAB]) begin
        first_linestore_we <= 1'b0;
        grab_done_r <= 1'b0;
      end else if (hs_edge) begin
        first_linestore_we <= !grab_done_r && !first_linestore_we;
        grab_done_r <= grab_done_r || first_linestore_we;
      end
    end
  end

  // Clamp pulse generator: position count, then a fixed-width low pulse
  vop_pkg::vop_clamp_st_t clp_st_r;
  logic [7:0] clp_cnt_r;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      clp_st_r <= vop_pkg::VOP_CLP_IDLE;
      clp_cnt_r <= 8'h00;
      aux_video_out_pin <= 1'b1;
    end else begin
      case (clp_st_r)
        vop_pkg::VOP_CLP_IDLE: begin
          aux_video_out_pin <= 1'b1;
          if (hs_edge) begin
            clp_st_r <= vop_pkg::VOP_CLP_WAIT;
            clp_cnt_r <= clamp_pos_r;
          end
        end
        vop_pkg::VOP_CLP_WAIT: begin
          if (clp_cnt_r == 8'h00) begin
            clp_st_r <= vop_pkg::VOP_CLP_PULSE;
            clp_cnt_r <= 8'(vop_pkg::CLAMP_CYCLES - 8'h01);
            aux_video_out_pin <= !clamp_ctrl_r[vop_pkg::CLAMP_EN_BIT];
          end else begin
            clp_cnt_r <= 8'(clp_cnt_r - 8'h01);
          end
        end
        vop_pkg::VOP_CLP_PULSE: begin
          if (clp_cnt_r == 8'h00) begin
            clp_st_r <= vop_pkg::VOP_CLP_IDLE;
            aux_video_out_pin <= 1'b1;
          end else begin
            clp_cnt_r <= 8'(clp_cnt_r - 8'h01);
          end
        end
        default: begin
          clp_st_r <= vop_pkg::VOP_CLP_IDLE;
          aux_video_out_pin <= 1'b1;
        end
      endcase
    end
  end

  // Chroma path per channel: demod bypass, Gaussian LPF or bypass, coring
  logic signed [DW-1:0] c_in [2];
  logic signed [DW-1:0] c_s1 [2];
  assign c_in[0] = ctrl_a_r[vop_pkg::A_DEMOD_BY] ? comp_u : in_pix.u;
  assign c_in[1] = ctrl_a_r[vop_pkg::A_DEMOD_BY] ? comp_v : in_pix.v;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chroma
      logic signed [DW-1:0] h_r [4];
      logic signed [DW+3:0] f1, f2;
      logic signed [DW-1:0] sel;
      logic [DW-1:0] mag;
      // Both filters center on the second history tap so the choice keeps latency
      assign f1 = (DW+4)'(h_r[0]) + ((DW+4)'(h_r[1]) <<< 1) + (DW+4)'(h_r[2]) + 14'sd2;
      assign f2 = (DW+4)'(c_in[ch]) + ((DW+4)'(h_r[0]) <<< 2) + 14'sd8
                + (DW+4)'(h_r[1]) * 14'sd6 + ((DW+4)'(h_r[2]) <<< 2) + (DW+4)'(h_r[3]);
      always_comb begin
        if (ctrl_a_r[vop_pkg::A_GAUSS_BY]) begin
          sel = h_r[1];
        end else if (ctrl_a_r[vop_pkg::A_FILT2]) begin
          sel = DW'(f2 >>> 4);
        end else begin
          sel = DW'(f1 >>> 2);
        end
        mag = sel[DW-1] ? DW'(-sel) : DW'(sel);
      end
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          h_r <= '{default: '0};
          c_s1[ch] <= '0;
        end else if (in_valid && adv) begin
          h_r[0] <= c_in[ch];
          h_r[1] <= h_r[0];
          h_r[2] <= h_r[1];
          h_r[3] <= h_r[2];
          // Small chroma is treated as noise and zeroed
          if (ctrl_a_r[vop_pkg::A_CCORE_EN] && mag < DW'(core_thr_r)) begin
            c_s1[ch] <= '0;
          end else begin
            c_s1[ch] <= sel;
          end
        end
      end
    end
  endgenerate

  // Stage 1: luma capture and clamp level sampled on the burst gate edge
  logic [DW-1:0] y_s1, y_prev_r;
  logic blk_s1;
  logic signed [12:0] blank_r;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      y_s1 <= '0;
      y_prev_r <= '0;
      blk_s1 <= 1'b0;
      blank_r <= vop_pkg::BLANK_240;
    end else begin
      if (in_valid && adv) begin
        y_s1 <= in_pix.y;
        y_prev_r <= y_s1;
        blk_s1 <= burst_blank;
      end
      if (gate_edge) begin
        case (ctrl_b_r[vop_pkg::B_BLANK_LO +: 2])
          2'b00: blank_r <= vop_pkg::BLANK_240;
          2'b01: blank_r <= vop_pkg::BLANK_256;
          2'b10: blank_r <= 13'(ext_video_input);
          default: blank_r <= 13'((11'(y_s1) + 11'(y_prev_r)) >> 1);
        endcase
      end
    end
  end

  // Stage 2: blanking removal, then pedestal on pure luma only
  logic signed [12:0] diff, ped;
  logic signed [12:0] y_s2;
  logic blk_s2;
  logic signed [DW-1:0] u_s2, v_s2;
  assign diff = 13'(y_s1) - blank_r;
  assign ped = diff - 13'(pedestal_r);
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      y_s2 <= '0;
      blk_s2 <= 1'b0;
      u_s2 <= '0;
      v_s2 <= '0;
    end else if (adv) begin
      blk_s2 <= blk_s1;
      u_s2 <= c_s1[0];
      v_s2 <= c_s1[1];
      if (diff < 0) begin
        y_s2 <= diff;
      end else if (ped < 0 && !sb_ctrl_r[vop_pkg::SB_PASS_BIT]) begin
        y_s2 <= '0;
      end else begin
        y_s2 <= ped;
      end
    end
  end

  // Stage 3: adaptive notch and fixed quarter-rate notch on luma
  logic signed [12:0] yh0_r, yh1_r, d1, d2, a1, a2, anf, lnf, y_fil;
  logic [11:0] thr;
  logic an_bypass;
  logic signed [12:0] y_s3;
  logic blk_s3;
  logic signed [DW-1:0] u_s3, v_s3;
  assign d1 = y_s2 - yh0_r;
  assign d2 = yh0_r - yh1_r;
  assign a1 = d1 < 0 ? -d1 : d1;
  assign a2 = d2 < 0 ? -d2 : d2;
  always_comb begin
    case (ctrl_b_r[vop_pkg::B_THR_LO +: 2])
      2'b00: thr = vop_pkg::THR_0;
      2'b01: thr = vop_pkg::THR_1;
      2'b10: thr = vop_pkg::THR_2;
      default: thr = vop_pkg::THR_3;
    endcase
  end
  // Either neighbour difference at or above threshold marks an edge
  assign an_bypass = !ctrl_a_r[vop_pkg::A_ANOTCH_EN]
                   || 12'(a1) >= thr || 12'(a2) >= thr;
  assign anf = 13'((14'(y_s2) + (14'(yh0_r) <<< 1) + 14'(yh1_r)) >>> 2);
  assign lnf = 13'((14'(y_s2) + 14'(yh1_r) + 14'sd1) >>> 1);
  always_comb begin
    if (ctrl_a_r[vop_pkg::A_LNOTCH]) begin
      y_fil = lnf;
    end else begin
      y_fil = an_bypass ? yh0_r : anf;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      yh0_r <= '0;
      yh1_r <= '0;
      y_s3 <= '0;
      blk_s3 <= 1'b0;
      u_s3 <= '0;
      v_s3 <= '0;
    end else if (adv) begin
      yh0_r <= y_s2;
      yh1_r <= yh0_r;
      blk_s3 <= blk_s2;
      u_s3 <= u_s2;
      v_s3 <= v_s2;
      if (!ctrl_a_r[vop_pkg::A_CORING_OUTPUT_SIZE]) begin
        y_s3 <= y_fil;
      end else if (an_bypass && !ctrl_a_r[vop_pkg::A_LNOTCH]) begin
        y_s3 <= y_fil & ~13'sh0003;
      end else begin
        y_s3 <= (y_fil + 13'sh0002) & ~13'sh0003;
      end
    end
  end

  // Stage 4: scalars with rounding, gain chosen by blanking
  logic [9:0] yg;
  logic signed [24:0] py, pu, pv, pg;
  logic signed [13:0] y_s4, u_s4, v_s4, g_s4;
  assign yg = blk_s3 ? s_gain_r : y_gain_r;
  assign py = 25'(y_s3) * $signed({1'b0, yg}) + 25'sd128;
  assign pu = 25'(u_s3) * $signed({1'b0, u_gain_r}) + 25'sd128;
  assign pv = 25'(v_s3) * $signed({1'b0, v_gain_r}) + 25'sd128;
  assign pg = -(25'(v_s4) * 25'(vop_pkg::G_FROM_V)) - (25'(u_s4) * 25'(vop_pkg::G_FROM_U))
            + 25'sd1024;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      y_s4 <= '0;
      u_s4 <= '0;
      v_s4 <= '0;
    end else if (adv) begin
      y_s4 <= 14'(py >>> 8);
      u_s4 <= 14'(pu >>> 8);
      v_s4 <= 14'(pv >>> 8);
    end
  end
  assign g_s4 = 14'(pg >>> 11);

  // Stage 5: offset and limiters; output magnitude only via the three gains
  function automatic logic [DW-1:0] lim(input logic signed [14:0] x,
                                        input logic signed [13:0] lo,
                                        input logic signed [13:0] hi);
    logic signed [14:0] r;
    r = x;
    if (x < 15'(lo)) begin
      r = 15'(lo);
    end
    if (x > 15'(hi)) begin
      r = 15'(hi);
    end
    return DW'(r);
  endfunction
  logic rgb, std_rng;
  logic signed [14:0] yo, r_sum, g_sum, b_sum;
  logic signed [13:0] ylo, yhi, clim;
  vop_pkg::vop_out_t res;
  assign rgb = !ctrl_b_r[vop_pkg::B_LMT_LO];
  assign std_rng = ctrl_b_r[vop_pkg::B_LMT_LO + 1];
  assign yo = 15'(y_s4) + 15'(y_offset_r);
  assign r_sum = yo + 15'(v_s4);
  assign g_sum = yo + 15'(g_s4);
  assign b_sum = yo + 15'(u_s4);
  assign ylo = std_rng ? vop_pkg::LIM_STD_LO : 14'sh0000;
  assign yhi = std_rng ? vop_pkg::LIM_STD_HI : vop_pkg::LIM_FULL_HI;
  assign clim = std_rng ? vop_pkg::LIM_C_STD : vop_pkg::LIM_C_FULL;
  always_comb begin
    if (rgb) begin
      res.g_y = lim(g_sum, ylo, yhi);
      res.r_v = lim(r_sum, ylo, yhi);
      res.b_u = lim(b_sum, ylo, yhi);
    end else begin
      res.g_y = lim(yo, ylo, yhi);
      res.b_u = lim(15'(u_s4), -clim, clim);
      res.r_v = lim(15'(v_s4), -clim, clim);
    end
  end

  // Valid bits walk with the data so latency is fixed at five advances
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      vld_r <= 5'h00;
    end else if (adv) begin
      vld_r <= {vld_r[3:0], in_valid};
    end
  end

  // Stage 5 writes straight into the FIFO; its ready stalls every stage
  vop_fifo #(
    .WIDTH(3 * DW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .wr_valid(vld_r[3] && adv),
    .wr_ready(in_ready),
    .wr_data(res),
    .rd_valid(out_valid),
    .rd_ready(out_ready),
    .rd_data(out_pix)
  );
endmodule

`default_nettype wire

// ==== tb/vop_src_model.sv ====
// Upstream pixel source model: valid/ready handshake, one pixel at a time
`timescale 1ns/1ps
`default_nettype none
module vop_src_model (
  input wire logic core_clk,
  input wire logic in_ready,
  output logic in_valid,
  output vop_pkg::vop_pix_t in_pix
);
  initial begin
    in_valid = 1'b0;
    in_pix = '0;
  end
  // Plain luma with no subcarrier, so the host keeps demodulation filter 1
  // Holds each pixel until taken; released data is inverted so stale words never look valid
  task automatic send(input logic [9:0] y, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      in_valid <= 1'b1;
      in_pix <= '{y, 10'sd0, 10'sd0};
      do @(posedge core_clk); while (in_ready !== 1'b1);
      in_valid <= 1'b0;
      in_pix <= ~in_pix;
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/vop_output_processor_chk.sv ====
// Port-level assertions for the video output processor
`timescale 1ns/1ps
`default_nettype none
module vop_output_processor_chk (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] up_addr,
  input wire logic [7:0] up_wdata,
  input wire logic up_wr,
  input wire logic up_rd,
  input wire logic [7:0] up_rdata,
  input wire logic hsync,
  input wire logic [7:0] burst_err,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire vop_pkg::vop_out_t out_pix,
  input wire logic aux_video_out_pin,
  input wire logic first_linestore_we,
  input wire logic comb_force_simple
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic hs_q, en_r, grab_r;
  logic [7:0] pos_r, err_r;
  // Shadow of host writes and line-rate capture, so reads can be predicted
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hs_q <= 1'b0;
      en_r <= 1'b0;
      grab_r <= 1'b0;
      pos_r <= 8'h00;
      err_r <= 8'h00;
    end else begin
      hs_q <= hsync;
      if (hsync && !hs_q) err_r <= burst_err;
      if (up_wr && up_addr == vop_pkg::REG_CLAMP_POS) pos_r <= up_wdata;
      if (up_wr && up_addr == vop_pkg::REG_CLAMP_CTRL) en_r <= up_wdata[7];
      if (up_wr && up_addr == vop_pkg::REG_CTRL_A) grab_r <= up_wdata[4];
    end
  end
  a_err_readback: assert property (up_rd && up_addr == vop_pkg::REG_BURST_ERR
    |=> up_rdata == $past(err_r)) else $error("burst error read mismatch");
  a_pos_readback: assert property (up_rd && up_addr == vop_pkg::REG_CLAMP_POS
    |=> up_rdata == $past(pos_r)) else $error("clamp position read mismatch");
  a_clamp_start: assert property ($rose(hsync) && en_r && pos_r == 8'h03
    |-> ##5 $fell(aux_video_out_pin)) else $error("clamp pulse start wrong");
  a_clamp_width: assert property ($fell(aux_video_out_pin)
    |-> !aux_video_out_pin [*5] ##1 aux_video_out_pin) else $error("clamp pulse width wrong");
  a_clamp_gated: assert property ($fell(aux_video_out_pin) |-> en_r)
    else $error("clamp pulse while disabled");
  a_grab_force: assert property ($rose(grab_r) |-> ##[0:2] comb_force_simple)
    else $error("comb not forced simple");
  a_grab_line: assert property ($changed(first_linestore_we) |-> $past(hsync))
    else $error("linestore write not line aligned");
  a_out_hold: assert property (out_valid && !out_ready
    |=> out_valid && $stable(out_pix)) else $error("output word dropped while stalled");
  c_clamp: cover property ($fell(aux_video_out_pin));
  c_stall: cover property (out_valid && !out_ready);
  c_grab: cover property ($rose(first_linestore_we));
endmodule
bind vop_output_processor vop_output_processor_chk chk_u (.*);
`default_nettype wire

// ==== tb/vop_output_processor_test.sv ====
// Self-checking bench for the video output processor
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin miscompares++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module vop_output_processor_test;
  logic core_clk = 0, rstn = 0, up_wr = 0, up_rd = 0, hsync = 0, burst_gate = 0, out_ready = 1;
  logic burst_blank = 0, in_valid, in_ready, out_valid, aux_video_out_pin;
  logic first_linestore_we, comb_force_simple;
  logic [7:0] up_addr = 8'h00, up_wdata = 8'h00, burst_err = 8'h00, up_rdata, v;
  logic signed [9:0] comp_u = 10'sh000, comp_v = 10'sh000;
  logic [9:0] ext_video_input = 10'h000;
  vop_pkg::vop_pix_t in_pix;
  vop_pkg::vop_out_t out_pix, last_pix;
  int checks_done = 0, miscompares = 0, rx_cnt = 0, n, w;
  vop_output_processor dut_u (.*);
  vop_src_model src_u (.*);
  always #50 core_clk = ~core_clk;
  // Sink: keep the last word and count words
  always @(posedge core_clk) if (out_valid && out_ready) begin
    last_pix <= out_pix;
    rx_cnt <= rx_cnt + 1;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    up_addr <= a; up_wdata <= d; up_wr <= 1'b1;
    @(posedge core_clk);
    up_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    up_addr <= a; up_rd <= 1'b1;
    @(posedge core_clk);
    up_rd <= 1'b0;
    #1 v = up_rdata;
  endtask
  // One line: hsync and burst gate high then low, loop error presented on the rise
  task automatic hs(input logic [7:0] e);
    @(posedge core_clk);
    hsync <= 1'b1; burst_gate <= 1'b1; burst_err <= e;
    repeat (12) @(posedge core_clk);
    hsync <= 1'b0; burst_gate <= 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
  endtask
  task automatic test_clamp_err();
    wr(vop_pkg::REG_CLAMP_CTRL, 8'h80); wr(vop_pkg::REG_CLAMP_POS, 8'h03);
    rd(vop_pkg::REG_CLAMP_POS); `CHK("pos", 8'h03, v)
    @(posedge core_clk);
    hsync <= 1'b1; burst_gate <= 1'b1; burst_err <= 8'hA5; n = 0; w = 0;
    do begin @(posedge core_clk); #1 n++; end while (aux_video_out_pin !== 1'b0 && n < 20);
    do begin @(posedge core_clk); #1 w++; end while (aux_video_out_pin === 1'b0 && w < 20);
    `CHK("start", 5, n)
    `CHK("width", 5, w)
    @(posedge core_clk);
    hsync <= 1'b0; burst_gate <= 1'b0;
    rd(vop_pkg::REG_BURST_ERR); `CHK("err", 8'hA5, v)
    wr(vop_pkg::REG_BURST_ERR, 8'h00); wr(vop_pkg::REG_CLAMP_CTRL, 8'h00);
    rd(vop_pkg::REG_BURST_ERR); `CHK("err ro", 8'hA5, v)
  endtask
  task automatic test_grab();
    wr(vop_pkg::REG_CTRL_A, 8'h10); repeat (3) @(posedge core_clk); #1;
    `CHK("force", 1'b1, comb_force_simple)
    hs(8'h11); `CHK("grab on", 1'b1, first_linestore_we)
    rd(vop_pkg::REG_BURST_ERR); `CHK("err line", 8'h11, v)
    hs(8'h22); `CHK("grab off", 1'b0, first_linestore_we)
    wr(vop_pkg::REG_CTRL_A, 8'h00);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("force off", 1'b0, comb_force_simple)
  endtask
  // Steady luma through clamp, offset and limiter; chroma zero
  task automatic test_pix(input logic [9:0] y, input logic [7:0] b, input logic [7:0] o,
      input logic [9:0] e);
    wr(vop_pkg::REG_CTRL_B, b); wr(vop_pkg::REG_Y_OFFSET, o);
    src_u.send(y, 24); repeat (30) @(posedge core_clk);
    `CHK("pix", b[4] ? {e, 20'h00000} : {e, e, e}, last_pix)
  endtask
  task automatic test_fill();
    @(posedge core_clk);
    out_ready <= 1'b0; n = rx_cnt;
    fork src_u.send(10'd500, 40); join_none
    repeat (200) @(posedge core_clk); #1;
    `CHK("full", 1'b0, in_ready)
    @(posedge core_clk);
    out_ready <= 1'b1;
    repeat (200) @(posedge core_clk);
    `CHK("count", 40, rx_cnt - n)
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence: reset, then each scenario
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    test_clamp_err();
    test_grab();
    test_pix(10'd500, 8'h00, 8'h40, 10'd324);
    for (int k = 0; k < 4; k++) test_pix(10'h3FF, 8'(k * 16), 8'hFF, k > 1 ? 10'd940 : 10'd1023);
    // Latch the 256 level, then the external level with a pedestal on top
    wr(vop_pkg::REG_CTRL_B, 8'h01);
    hs(8'h00);
    test_pix(10'd500, 8'h01, 8'h40, 10'd308);
    ext_video_input <= 10'd100;
    wr(vop_pkg::REG_CTRL_B, 8'h02);
    wr(vop_pkg::REG_PEDESTAL, 8'h20);
    hs(8'h00);
    test_pix(10'd500, 8'h02, 8'h40, 10'd432);
    test_fill();
    finish_test();
  end
  // Watchdog well beyond the thousand or so cycles the scenarios need
  initial begin
    #(6000 * 100);
    miscompares++;
    finish_test();
  end
endmodule
`default_nettype wire
